// *** src/adc_readout_pkg.sv ***
// shared constants for the serial converter readout block
package adc_readout_pkg;
  localparam int RESULT_BITS_DEFAULT = 14;
  localparam int WORD_SLOTS = 16;
  localparam int ACQ_EDGE = 16;
  localparam int NAP_TRIGGERS = 2;
  localparam int SLEEP_TRIGGERS = 4;
  localparam int SETUP_NS = 3;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETUP_CYCLES = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] SLOT_RESET = 5'h00;
  typedef enum logic [2:0] {
    PWR_ACTIVE = 3'b001,
    PWR_NAP = 3'b010,
    PWR_SLEEP = 3'b100
  } pwr_state_t;
endpackage : adc_readout_pkg

// *** src/adc_sample_buffer.sv ***
// two-entry valid/ready buffer for captured samples
`timescale 1ns/1ps
`default_nettype none
module adc_sample_buffer #(
  parameter int WIDTH = 14
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  logic [WIDTH-1:0] mem_q [2];
  logic wr_q;
  logic rd_q;
  logic [1:0] cnt_q;
  logic push;
  logic pop;
  assign o_in_ready = (cnt_q != 2'h2);
  assign o_out_valid = (cnt_q != 2'h0);
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_data = mem_q[rd_q];
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'h0;
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end
    else
    begin
      if (push)
      begin
        mem_q[wr_q] <= i_in_data;
        wr_q <= ~wr_q;
      end
      if (pop)
      begin
        rd_q <= ~rd_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : adc_sample_buffer
`default_nettype wire

// *** src/adc_readout.sv ***
// conversion sequencing, power-down and serial readout of the converter
`timescale 1ns/1ps
`default_nettype none
module adc_readout #(
  parameter int RESULT_BITS = adc_readout_pkg::RESULT_BITS_DEFAULT,
  parameter int SAMPLE_BITS = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_conversion_trigger,
  input wire logic i_shift_clk,
  input wire logic [SAMPLE_BITS-1:0] i_input_difference,
  input wire logic i_input_valid,
  output logic o_input_ready,
  output logic o_serial_result_out,
  output logic o_serial_result_oe,
  output logic o_sample_hold,
  output logic o_acquiring,
  output logic o_nap,
  output logic o_sleep,
  output logic o_reference_on
);
  import adc_readout_pkg::*;

  if (RESULT_BITS != 12 && RESULT_BITS != 14)
  begin : g_bad_result_bits
    $error("result width must be 12 or 14");
  end
  // the clamp needs a sign bit and at least one over-range bit
  if (SAMPLE_BITS < RESULT_BITS + 2)
  begin : g_bad_sample_bits
    $error("sample width too narrow");
  end

  // trigger and shift clock pins cross in through two flops before anything looks at them
  logic trig_s1_q;
  logic trig_s2_q;
  logic trig_prev_q;
  logic sck_s1_q;
  logic sck_s2_q;
  logic sck_prev_q;
  logic trig_rise;
  logic sck_rise;

  // trigger pin: two flops, then one more to find its rising edge
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      trig_prev_q <= 1'b0;
    end
    else
    begin
      trig_s1_q <= i_conversion_trigger;
      trig_s2_q <= trig_s1_q;
      trig_prev_q <= trig_s2_q;
    end
  end

  // shift clock pin, same treatment
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      sck_s1_q <= 1'b0;
      sck_s2_q <= 1'b0;
      sck_prev_q <= 1'b0;
    end
    else
    begin
      sck_s1_q <= i_shift_clk;
      sck_s2_q <= sck_s1_q;
      sck_prev_q <= sck_s2_q;
    end
  end

  assign trig_rise = trig_s2_q && !trig_prev_q;
  assign sck_rise = sck_s2_q && !sck_prev_q;

  // analog front end modelled as a stream of signed differences
  logic buf_valid;
  logic buf_ready;
  logic [SAMPLE_BITS-1:0] buf_data;

  adc_sample_buffer #(
    .WIDTH(SAMPLE_BITS)
  ) u_sample_buffer (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(i_input_valid),
    .o_in_ready(o_input_ready),
    .i_in_data(i_input_difference),
    .o_out_valid(buf_valid),
    .i_out_ready(buf_ready),
    .o_out_data(buf_data)
  );

  // buffer drains only at a conversion start, so a stalled source waits
  assign buf_ready = trig_rise;

  // clamp signed difference into the unsigned code range
  function automatic logic [RESULT_BITS-1:0] to_code(
    input logic [SAMPLE_BITS-1:0] diff
  );
    logic [RESULT_BITS-1:0] code;
    code = diff[RESULT_BITS-1:0];
    if (diff[SAMPLE_BITS-1])
      code = '0;
    else if (diff[SAMPLE_BITS-2:RESULT_BITS] != '0)
      code = '1;
    return code;
  endfunction : to_code

  // power state
  pwr_state_t pwr_q;
  pwr_state_t pwr_d;
  logic [2:0] idle_trig_q;
  logic [2:0] idle_trig_d;

  // triggers since the last shift edge, held at the sleep count
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      idle_trig_q <= 3'h0;
    else if (sck_rise)
      idle_trig_q <= 3'h0;
    else if (trig_rise)
      idle_trig_q <= idle_trig_d;
  end

  assign idle_trig_d = (idle_trig_q == 3'(SLEEP_TRIGGERS)) ?
                       idle_trig_q : idle_trig_q + 3'h1;

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      pwr_q <= PWR_ACTIVE;
    else
      pwr_q <= pwr_d;
  end

  // a shift edge in the cycle of a trigger wins, so no wake is lost
  always_comb
  begin
    pwr_d = pwr_q;
    case (pwr_q)
      PWR_ACTIVE, PWR_NAP:
      begin
        if (sck_rise)
          pwr_d = PWR_ACTIVE;
        else if (trig_rise && idle_trig_d >= 3'(SLEEP_TRIGGERS))
          pwr_d = PWR_SLEEP;
        else if (trig_rise && idle_trig_d >= 3'(NAP_TRIGGERS))
          pwr_d = PWR_NAP;
      end
      PWR_SLEEP:
      begin
        if (sck_rise)
          pwr_d = PWR_ACTIVE;
      end
      default:
        pwr_d = PWR_ACTIVE;
    endcase
  end

  assign o_nap = (pwr_q == PWR_NAP);
  assign o_sleep = (pwr_q == PWR_SLEEP);
  assign o_reference_on = (pwr_q != PWR_SLEEP);

  // conversion sequence
  logic [4:0] slot_q;
  logic hold_q;
  logic acq_q;
  logic late_q;
  logic [RESULT_BITS-1:0] held_code_q;
  logic [RESULT_BITS-1:0] shift_q;
  logic out_q;
  logic oe_q;
  logic [3:0] since_trig_q;
  logic [4:0] first_slot;

  logic late_now;
  logic step;
  logic in_word;
  logic [4:0] slot_d;

  // a trigger caught closer than the setup time costs a whole slot
  assign late_now = late_q ||
                    (slot_q == SLOT_RESET && since_trig_q < 4'(SETUP_CYCLES));
  assign first_slot = late_now ? 5'h02 : 5'h01;
  // shift edges count only while holding; a trigger takes the cycle
  assign step = sck_rise && hold_q && !trig_rise;
  assign slot_d = slot_q + 5'h01;
  assign in_word = (slot_d >= first_slot) &&
                   (slot_d < first_slot + 5'(RESULT_BITS));

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      since_trig_q <= 4'hf;
    else if (trig_rise)
      since_trig_q <= 4'h0;
    else if (since_trig_q != 4'hf)
      since_trig_q <= since_trig_q + 4'h1;
  end

  // an edge arriving with the trigger is the first one, but it is late
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      slot_q <= SLOT_RESET;
      late_q <= 1'b0;
    end
    else if (trig_rise)
    begin
      slot_q <= sck_rise ? SLOT_RESET + 5'h01 : SLOT_RESET;
      late_q <= sck_rise;
    end
    else if (step)
    begin
      // no time limit between edges, so slow readout just waits
      slot_q <= slot_d;
      late_q <= late_now;
    end
  end

  // sample and hold status
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      hold_q <= 1'b0;
      acq_q <= 1'b1;
    end
    else if (trig_rise)
    begin
      hold_q <= 1'b1;
      acq_q <= 1'b0;
    end
    else if (step && slot_d == 5'(ACQ_EDGE))
    begin
      hold_q <= 1'b0;
      acq_q <= 1'b1;
    end
  end

  // an empty buffer leaves the last frozen code in place
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      held_code_q <= '0;
    else if (trig_rise && buf_valid)
      held_code_q <= to_code(buf_data);
  end

  // the word sent is the one frozen one conversion earlier
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      shift_q <= '0;
    else if (trig_rise)
      shift_q <= held_code_q;
    else if (step && in_word)
      shift_q <= {shift_q[RESULT_BITS-2:0], 1'b0};
  end

  // a trigger mid-word aborts it and releases the output
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      out_q <= 1'b0;
      oe_q <= 1'b0;
    end
    else if (trig_rise)
    begin
      out_q <= 1'b0;
      oe_q <= 1'b0;
    end
    else if (step)
    begin
      out_q <= in_word && shift_q[RESULT_BITS-1];
      oe_q <= in_word;
    end
  end

  assign o_serial_result_out = out_q;
  assign o_serial_result_oe = oe_q;
  assign o_sample_hold = hold_q;
  assign o_acquiring = acq_q;
endmodule : adc_readout
`default_nettype wire

// *** tb/adc_readout_properties.sv ***
// assertions on the converter readout ports
`timescale 1ns/1ps
`default_nettype none
module adc_readout_properties (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_conversion_trigger,
  input wire logic i_shift_clk,
  input wire logic o_serial_result_out,
  input wire logic o_serial_result_oe,
  input wire logic o_sample_hold,
  input wire logic o_acquiring,
  input wire logic o_nap,
  input wire logic o_sleep,
  input wire logic o_reference_on
);
  default clocking @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);
  a_quiet_out: assert property (!o_serial_result_oe |-> !o_serial_result_out)
    else $error("data while released");
  a_hold_acq_pair: assert property (o_acquiring != o_sample_hold)
    else $error("acquire and hold agree");
  a_ref_sleep_tie: assert property (o_reference_on == !o_sleep)
    else $error("reference state wrong");
  a_power_onehot: assert property (!(o_nap && o_sleep))
    else $error("nap and sleep together");
  a_trig_holds: assert property ($rose(i_conversion_trigger) |-> ##[1:6] o_sample_hold)
    else $error("trigger did not hold");
  a_shift_wakes: assert property ($rose(i_shift_clk) |-> ##[1:6] !o_sleep)
    else $error("shift edge did not wake");
  // a quiet link must leave the output alone, however slow the shift clock
  a_out_stands: assert property (($stable(i_shift_clk) && $stable(i_conversion_trigger)) [*6]
    |=> $stable(o_serial_result_out) && $stable(o_serial_result_oe))
    else $error("output moved on a quiet link");
  a_word_in_hold: assert property ($rose(o_serial_result_oe) |-> o_sample_hold)
    else $error("word outside conversion");
endmodule : adc_readout_properties
bind adc_readout adc_readout_properties i_props (.i_ref_clk, .i_rst_n,
  .i_conversion_trigger, .i_shift_clk, .o_serial_result_out,
  .o_serial_result_oe, .o_sample_hold, .o_acquiring, .o_nap, .o_sleep,
  .o_reference_on);
`default_nettype wire

// *** tb/adc_host_model.sv ***
// host model driving trigger and shift clock
`timescale 1ns/1ps
`default_nettype none
module adc_host_model #(
  parameter int SETTLE = 20
) (
  input wire logic i_ref_clk,
  input wire logic i_data,
  input wire logic i_data_oe,
  output logic o_trigger,
  output logic o_shift
);
  logic [15:0] word_q = 16'h0000;
  int first_q = 0;
  initial o_trigger = 1'b0;
  initial o_shift = 1'b0;
  task automatic gap(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask : gap
  // late raises trigger and first shift edge together
  task automatic convert(input int half, input bit late, input int edges);
    word_q = 16'h0000;
    first_q = 0;
    o_trigger = 1'b1;
    if (!late) gap(half);
    for (int e = 1; e <= edges; e++)
    begin
      if (i_data_oe === 1'b1)
      begin
        word_q = {word_q[14:0], i_data};
        if (first_q == 0) first_q = e;
      end
      o_shift = 1'b1;
      gap(half);
      o_trigger = 1'b0;
      o_shift = 1'b0;
      gap(half);
    end
    o_trigger = 1'b0;
    gap(half);
  endtask : convert
  // settle wait shortened so the run stays short
  task automatic wake;
    o_shift = 1'b1;
    gap(4);
    o_shift = 1'b0;
    gap(SETTLE);
  endtask : wake
endmodule : adc_host_model
`default_nettype wire

// *** tb/adc_readout_test.sv ***
// self-checking bench for the converter readout block
`timescale 1ns/1ps
`default_nettype none
module adc_readout_test;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_input_valid = 1'b0;
  logic [15:0] i_input_difference = 16'h0000;
  logic i_conversion_trigger, i_shift_clk, o_input_ready, o_nap, o_sleep;
  logic o_serial_result_out, o_serial_result_oe, o_sample_hold;
  logic o_acquiring, o_reference_on;
  int bad_count = 0;
  int total_checks = 0;
  logic [15:0] smp [5] = '{16'h1234, 16'hfffb, 16'h7fff, 16'h3fff, 16'h0001};
  always #5 i_ref_clk = ~i_ref_clk;
  adc_readout i_dut (.i_ref_clk, .i_rst_n, .i_conversion_trigger,
    .i_shift_clk, .i_input_difference, .i_input_valid, .o_input_ready,
    .o_serial_result_out, .o_serial_result_oe, .o_sample_hold,
    .o_acquiring, .o_nap, .o_sleep, .o_reference_on);
  adc_host_model i_host (.i_ref_clk, .i_data(o_serial_result_out),
    .i_data_oe(o_serial_result_oe), .o_trigger(i_conversion_trigger),
    .o_shift(i_shift_clk));
  task automatic check_word(input string what, input logic [15:0] exp,
    input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word
  task automatic check_flag(input string what, input logic exp, input logic got);
    check_word(what, 16'(exp), 16'(got));
  endtask : check_flag
  function automatic logic [15:0] clip(input logic [15:0] v);
    if (v[15]) return 16'h0000;
    return (v > 16'h3fff) ? 16'h3fff : v;
  endfunction : clip
  task automatic push(input logic [15:0] v);
    i_input_difference = v;
    i_input_valid = 1'b1;
    @(negedge i_ref_clk);
    i_input_valid = 1'b0;
  endtask : push
  task automatic t_reset_state;
    check_flag("oe", 1'b0, o_serial_result_oe);
    check_flag("acquiring", 1'b1, o_acquiring);
    check_flag("sleep", 1'b0, o_sleep | o_nap);
    check_flag("ready", 1'b1, o_input_ready);
  endtask : t_reset_state
  // buffer filled first; one slow and one late conversion in the stream
  task automatic t_stream;
    push(smp[0]);
    push(smp[1]);
    check_flag("ready", 1'b0, o_input_ready);
    for (int i = 0; i < 5; i++)
    begin
      i_host.convert(i == 2 ? 40 : 4, i == 4, 16);
      check_flag("acquiring", 1'b1, o_acquiring);
      if (i > 0) check_word("word", clip(smp[i - 1]), i_host.word_q);
      if (i > 0) check_word("first", (i == 4) ? 16'h0003 : 16'h0002,
        16'(i_host.first_q));
      if (i < 3) push(smp[i + 2]);
    end
  endtask : t_stream
  task automatic t_power;
    for (int k = 1; k < 5; k++)
    begin
      i_host.convert(4, 1'b0, 0);
      check_flag("hold", 1'b1, o_sample_hold);
      check_flag("nap", k == 2 || k == 3, o_nap);
      check_flag("sleep", k == 4, o_sleep);
    end
    check_flag("reference", 1'b0, o_reference_on);
    i_host.wake();
    check_flag("sleep", 1'b0, o_sleep);
    check_flag("reference", 1'b1, o_reference_on);
  endtask : t_power
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (16) @(negedge i_ref_clk);
    i_rst_n = 1'b1;
    @(negedge i_ref_clk);
    t_reset_state();
    t_stream();
    t_power();
    tally_and_finish();
  end
  initial
  begin
    #200000;
    bad_count++;
    tally_and_finish();
  end
endmodule : adc_readout_test
`default_nettype wire
